//--- design/gpk_lane_reg.sv
// 16-bit control register with byte-lane writes and synchronous clear
module gpk_lane_reg #(
   parameter logic [gpk_pkg::PIN_W-1:0] RST_VAL = gpk_pkg::PIN_DIR_RST
) (
   // clock and clear
   input wire logic clk,
   input wire logic clr,
   // write port
   input wire logic we,
   input wire logic [gpk_pkg::PIN_W-1:0] wdata,
   input wire logic [gpk_pkg::BE_W-1:0] be,
   // stored value
   output logic [gpk_pkg::PIN_W-1:0] value
);
   logic [gpk_pkg::PIN_W-1:0] val_q;

   // unaddressed byte keeps its contents on a byte write
   always_ff @(posedge clk) begin
      if (clr) begin
         val_q <= RST_VAL;
      end else if (we) begin
         val_q <= gpk_pkg::lane_merge(val_q, wdata, be);
      end
   end

   assign value = val_q;
endmodule

//--- design/gpk_pin_sync.sv
// three-stage pin synchroniser with agreement filter
module gpk_pin_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // raw pins and filtered level
   input wire logic [gpk_pkg::PIN_W-1:0] pin_raw,
   output logic [gpk_pkg::PIN_W-1:0] pin_level
);
   logic [gpk_pkg::PIN_W-1:0] s1_q;
   logic [gpk_pkg::PIN_W-1:0] s2_q;
   logic [gpk_pkg::PIN_W-1:0] s3_q;
   logic [gpk_pkg::PIN_W-1:0] lvl_q;

   // first stage feeds only the second; metastability settles there
   always_ff @(posedge clk) begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   // accept a change per bit only once stages two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         lvl_q <= gpk_pkg::PIN_DATA_RST;
      end else begin
         lvl_q <= (lvl_q & ~(s2_q ~^ s3_q)) | (s3_q & (s2_q ~^ s3_q));
      end
   end

   assign pin_level = lvl_q;
endmodule

//--- design/gpk_pkg.sv
// constants, carriers and helpers shared by the port k data block
package gpk_pkg;
   localparam int unsigned PIN_W = 16;
   localparam int unsigned BUS_W = 32;
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned BE_W = 4;
   localparam int unsigned BYTE_W = 8;

   // register byte addresses
   localparam logic [ADDR_W-1:0] PIN_DATA_ADDR = 32'hFFFFF778;
   localparam logic [ADDR_W-1:0] PIN_DIR_ADDR = 32'hFFFFF77C;
   localparam logic [ADDR_W-1:0] PIN_FUNC_ADDR = 32'hFFFFF780;
   localparam logic [ADDR_W-1:0] BUS_GROUP_ADDR = 32'hFFFFF784;

   // reset values
   localparam logic [PIN_W-1:0] PIN_DATA_RST = 16'h0000;
   localparam logic [PIN_W-1:0] PIN_DIR_RST = 16'h0000;
   localparam logic [PIN_W-1:0] PIN_FUNC_RST = 16'h0000;
   localparam logic [PIN_W-1:0] BUS_GROUP_RST = 16'h0000;
   localparam logic [BUS_W-1:0] RDATA_IDLE = 32'h00000000;
   localparam logic [BUS_W-PIN_W-1:0] RDATA_PAD = 16'h0000;

   // byte lanes of the 16-bit register within the bus word
   localparam int unsigned LANE_LO = 0;
   localparam int unsigned LANE_HI = 1;

   // register bus request from the cpu side
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [BUS_W-1:0] wdata;
      logic [BE_W-1:0] be;
      logic wr;
      logic rd;
   } gpk_bus_req_s;

   // alternate peripheral function feeding a pin
   typedef struct packed {
      logic [PIN_W-1:0] out;
      logic [PIN_W-1:0] oe;
   } gpk_alt_s;

   // merge write data into a 16-bit value, byte by byte
   function automatic logic [PIN_W-1:0] lane_merge(input logic [PIN_W-1:0] old,
                                                    input logic [PIN_W-1:0] wd,
                                                    input logic [BE_W-1:0] be);
      logic [PIN_W-1:0] r;
      r = old;
      if (be[LANE_LO]) begin
         r[BYTE_W-1:0] = wd[BYTE_W-1:0];
      end
      if (be[LANE_HI]) begin
         r[PIN_W-1:BYTE_W] = wd[PIN_W-1:BYTE_W];
      end
      return r;
   endfunction
endpackage

//--- design/gpk_port.sv
// port k data register, pin drive and output-disable gating
//
// Operation
// - a 16-bit read/write data register holds one bit per port pin, bit n for pin n.
// - on a general output pin the written data bit is driven onto the pin.
// - on a general output pin a read returns the stored bit whatever the pin shows.
// - on a general input pin a read returns the pin level, not the stored bit.
// - on a general input pin a write updates the stored bit but leaves the pin alone.
// - direction 0 with another function: reads give the pin, writes only store.
// - direction 1 with another function: reads give the stored bit, writes leave the pin.
// - the data register clears on power-on reset (not watchdog) and on hardware standby.
// - the data register keeps its value through software standby and sleep.
// - byte and halfword accesses are both accepted with the same timing.
// - output disable low floats the bus-group pins, high lets them drive.
// - the output disable acts only on bus-group pins set as general outputs.
// - the output disable gates the drivers combinationally, with no clocking.
module gpk_port (
   // clock and resets
   input wire logic clk,
   input wire logic rst,
   input wire logic wdt_reset,
   input wire logic hw_standby,
   // register bus
   input wire gpk_pkg::gpk_bus_req_s bus_req,
   output logic [gpk_pkg::BUS_W-1:0] bus_rdata,
   // alternate function
   input wire gpk_pkg::gpk_alt_s alt_in,
   // pins
   input wire logic [gpk_pkg::PIN_W-1:0] pin_in,
   output logic [gpk_pkg::PIN_W-1:0] pin_out,
   output logic [gpk_pkg::PIN_W-1:0] pin_oe,
   // output disable pin
   input wire logic output_disable_n
);
   logic [gpk_pkg::PIN_W-1:0] data_q;
   logic [gpk_pkg::PIN_W-1:0] data_d;
   logic [gpk_pkg::PIN_W-1:0] pin_direction_bits;
   logic [gpk_pkg::PIN_W-1:0] func_sel;
   logic [gpk_pkg::PIN_W-1:0] bus_group;
   logic [gpk_pkg::PIN_W-1:0] pin_level;
   logic [gpk_pkg::PIN_W-1:0] readback;
   logic [gpk_pkg::PIN_W-1:0] wlane;
   logic [gpk_pkg::PIN_W-1:0] pin_out_q;
   logic [gpk_pkg::PIN_W-1:0] oe_q;
   logic [gpk_pkg::PIN_W-1:0] gpo_q;
   logic [gpk_pkg::PIN_W-1:0] od_kill;
   logic [gpk_pkg::BUS_W-1:0] rdata_q;
   logic data_clr;
   logic cfg_clr;
   logic hit_data;
   logic hit_dir;
   logic hit_func;
   logic hit_group;
   logic hit_any;

   // address decode of the four word registers
   assign hit_data = bus_req.addr == gpk_pkg::PIN_DATA_ADDR;
   assign hit_dir = bus_req.addr == gpk_pkg::PIN_DIR_ADDR;
   assign hit_func = bus_req.addr == gpk_pkg::PIN_FUNC_ADDR;
   assign hit_group = bus_req.addr == gpk_pkg::BUS_GROUP_ADDR;
   assign hit_any = hit_data | hit_dir | hit_func | hit_group;
   assign wlane = bus_req.wdata[gpk_pkg::PIN_W-1:0];

   // watchdog reset leaves the data alone but reloads configuration
   assign data_clr = rst | hw_standby;
   assign cfg_clr = rst | hw_standby | wdt_reset;

   // the store is written whatever the pin function is
   always_comb begin
      data_d = data_q;
      if (bus_req.wr && hit_data) begin
         data_d = gpk_pkg::lane_merge(data_q, wlane, bus_req.be);
      end
   end

   // software standby and sleep have no path here, so contents survive them
   always_ff @(posedge clk) begin
      if (data_clr) begin
         data_q <= gpk_pkg::PIN_DATA_RST;
      end else begin
         data_q <= data_d;
      end
   end

   // direction: 1 = output
   gpk_lane_reg #(
      .RST_VAL(gpk_pkg::PIN_DIR_RST)
   ) u_dir (
      .clk(clk),
      .clr(cfg_clr),
      .we(bus_req.wr && hit_dir),
      .wdata(wlane),
      .be(bus_req.be),
      .value(pin_direction_bits)
   );

   // function select: 1 = pin serves the alternate function
   gpk_lane_reg #(
      .RST_VAL(gpk_pkg::PIN_FUNC_RST)
   ) u_func (
      .clk(clk),
      .clr(cfg_clr),
      .we(bus_req.wr && hit_func),
      .wdata(wlane),
      .be(bus_req.be),
      .value(func_sel)
   );

   // marks pins that carry address or data bus lines
   gpk_lane_reg #(
      .RST_VAL(gpk_pkg::BUS_GROUP_RST)
   ) u_group (
      .clk(clk),
      .clr(cfg_clr),
      .we(bus_req.wr && hit_group),
      .wdata(wlane),
      .be(bus_req.be),
      .value(bus_group)
   );

   // pins pass the three-stage filter before software sees them
   gpk_pin_sync u_sync (
      .clk(clk),
      .rst(rst),
      .pin_raw(pin_in),
      .pin_level(pin_level)
   );

   // read source per bit depends on direction only
   assign readback = (pin_direction_bits & data_q) | (~pin_direction_bits & pin_level);

   // read data stand for the single cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= gpk_pkg::RDATA_IDLE;
      end else if (bus_req.rd && hit_data) begin
         rdata_q <= {gpk_pkg::RDATA_PAD, readback};
      end else if (bus_req.rd && hit_dir) begin
         rdata_q <= {gpk_pkg::RDATA_PAD, pin_direction_bits};
      end else if (bus_req.rd && hit_func) begin
         rdata_q <= {gpk_pkg::RDATA_PAD, func_sel};
      end else if (bus_req.rd && hit_group) begin
         rdata_q <= {gpk_pkg::RDATA_PAD, bus_group};
      end else begin
         rdata_q <= gpk_pkg::RDATA_IDLE;
      end
   end

   // output value: stored bit for general pins, alternate value otherwise
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_out_q <= gpk_pkg::PIN_DATA_RST;
      end else begin
         pin_out_q <= (~func_sel & data_q) | (func_sel & alt_in.out);
      end
   end

   // drive enable: general pins drive only as outputs, input writes never drive
   always_ff @(posedge clk) begin
      if (rst) begin
         oe_q <= gpk_pkg::PIN_DIR_RST;
         gpo_q <= gpk_pkg::PIN_DIR_RST;
      end else begin
         oe_q <= (~func_sel & pin_direction_bits) | (func_sel & alt_in.oe);
         gpo_q <= ~func_sel & pin_direction_bits & bus_group;
      end
   end

   // disable pin is used raw: it must float the bus even with the clock stopped,
   // at the cost of the enable output not coming straight from a flip-flop
   assign od_kill = gpo_q & {gpk_pkg::PIN_W{~output_disable_n}};

   assign pin_oe = oe_q & ~od_kill;
   assign pin_out = pin_out_q;
   assign bus_rdata = rdata_q;

   // read of the data word picks stored bit or pin per direction
   read_source_a: assert property (
      @(posedge clk) disable iff (rst)
      $past(bus_req.rd && hit_data) |->
         rdata_q[gpk_pkg::PIN_W-1:0] ==
         (($past(pin_direction_bits) & $past(data_q)) |
          (~$past(pin_direction_bits) & $past(pin_level))))
      else $error("data read returned wrong source");

   // input direction reads follow the filtered pin even when a function owns it
   input_read_a: assert property (
      @(posedge clk) disable iff (rst)
      ($past(bus_req.rd && hit_data) && $past(pin_direction_bits) == gpk_pkg::PIN_DIR_RST) |->
         rdata_q[gpk_pkg::PIN_W-1:0] == $past(pin_level))
      else $error("input read did not return pin level");

   // a halfword write lands whole on the next edge
   word_write_a: assert property (
      @(posedge clk) disable iff (rst || hw_standby)
      (bus_req.wr && hit_data && bus_req.be[gpk_pkg::LANE_HI:gpk_pkg::LANE_LO] == 2'h3) |=>
         data_q == $past(wlane))
      else $error("halfword write not stored");

   // a low-byte write leaves the high byte untouched
   byte_write_a: assert property (
      @(posedge clk) disable iff (rst || hw_standby)
      (bus_req.wr && hit_data && bus_req.be[gpk_pkg::LANE_HI:gpk_pkg::LANE_LO] == 2'h1) |=>
         data_q[gpk_pkg::PIN_W-1:gpk_pkg::BYTE_W] ==
         $past(data_q[gpk_pkg::PIN_W-1:gpk_pkg::BYTE_W]) &&
         data_q[gpk_pkg::BYTE_W-1:0] == $past(wlane[gpk_pkg::BYTE_W-1:0]))
      else $error("byte write disturbed other byte");

   // power-on reset and hardware standby clear the data, watchdog reset does not
   data_clear_a: assert property (
      @(posedge clk)
      $past(rst || hw_standby) |-> data_q == gpk_pkg::PIN_DATA_RST)
      else $error("data register not cleared");

   // after two cycles running without writes or clears the data hold on the next edge
   data_hold_a: assert property (
      @(posedge clk) disable iff (rst || hw_standby)
      (!(bus_req.wr && hit_data))[*2] |=> $stable(data_q))
      else $error("data register changed without a write");

   // general output pins carry the stored bit one cycle later
   gen_drive_a: assert property (
      @(posedge clk) disable iff (rst)
      !$past(rst) |->
         pin_out_q == (($past(~func_sel) & $past(data_q)) |
                       ($past(func_sel) & $past(alt_in.out))))
      else $error("pin output does not follow source");

   // general input pins never drive
   input_float_a: assert property (
      @(posedge clk) disable iff (rst)
      !$past(rst) |->
         (pin_oe & $past(~func_sel & ~pin_direction_bits)) == gpk_pkg::PIN_DIR_RST)
      else $error("general input pin is driven");

   // disable low floats every bus-group general output at once
   od_float_a: assert property (
      @(posedge clk) disable iff (rst)
      !output_disable_n |-> (pin_oe & gpo_q) == gpk_pkg::PIN_DIR_RST)
      else $error("bus pin driven while disabled");

   // disable never touches pins outside the gated set
   od_scope_a: assert property (
      @(posedge clk) disable iff (rst)
      (pin_oe & ~gpo_q) == (oe_q & ~gpo_q))
      else $error("disable gated a pin it must not");

   // unmapped reads answer zero
   unmapped_read_a: assert property (
      @(posedge clk) disable iff (rst)
      (bus_req.rd && !hit_any) |=> rdata_q == gpk_pkg::RDATA_IDLE)
      else $error("unmapped read not zero");

   // a function-owned input pin still reads back its filtered level
   func_in_read_a: assert property (
      @(posedge clk) disable iff (rst)
      $past(bus_req.rd && hit_data) |->
         (rdata_q[gpk_pkg::PIN_W-1:0] & $past(func_sel & ~pin_direction_bits)) ==
         ($past(pin_level) & $past(func_sel & ~pin_direction_bits)))
      else $error("function input pin read wrong");

   // a function-owned output pin reads back the stored bit
   func_out_read_a: assert property (
      @(posedge clk) disable iff (rst)
      $past(bus_req.rd && hit_data) |->
         (rdata_q[gpk_pkg::PIN_W-1:0] & $past(func_sel & pin_direction_bits)) ==
         ($past(data_q) & $past(func_sel & pin_direction_bits)))
      else $error("function output pin read wrong");

   // function-owned pins carry the function value, never the stored bit
   func_pin_a: assert property (
      @(posedge clk) disable iff (rst)
      !$past(rst) |->
         (pin_out_q & $past(func_sel)) == $past(alt_in.out & func_sel))
      else $error("stored bit reached a function pin");

   // a watchdog reset alone leaves the data register as it was
   wdt_keep_a: assert property (
      @(posedge clk) disable iff (rst || hw_standby)
      (wdt_reset && !(bus_req.wr && hit_data)) |=> $stable(data_q))
      else $error("watchdog reset changed the data");

   // read data stand one cycle only and rest at zero otherwise
   rdata_idle_a: assert property (
      @(posedge clk) disable iff (rst)
      !$past(bus_req.rd) |-> rdata_q == gpk_pkg::RDATA_IDLE)
      else $error("read data outside the answer cycle");

   // disable high leaves every registered enable as it is
   od_release_a: assert property (
      @(posedge clk) disable iff (rst)
      output_disable_n |-> pin_oe == oe_q)
      else $error("enable gated while disable is high");

   // disable low gates the enables in the same cycle, no flop between
   od_now_a: assert property (
      @(posedge clk) disable iff (rst)
      !output_disable_n |-> pin_oe == (oe_q & ~gpo_q))
      else $error("disable gating lags the pin");

   // a high-byte write leaves the low byte untouched
   byte_hi_write_a: assert property (
      @(posedge clk) disable iff (rst || hw_standby)
      (bus_req.wr && hit_data && bus_req.be[gpk_pkg::LANE_HI:gpk_pkg::LANE_LO] == 2'h2) |=>
         data_q[gpk_pkg::BYTE_W-1:0] == $past(data_q[gpk_pkg::BYTE_W-1:0]) &&
         data_q[gpk_pkg::PIN_W-1:gpk_pkg::BYTE_W] ==
         $past(wlane[gpk_pkg::PIN_W-1:gpk_pkg::BYTE_W]))
      else $error("high byte write disturbed low byte");
endmodule

//--- sim/gpk_pins_model.sv
// outside circuitry hanging on the port pins
module gpk_pins_model (
   // device pin drive
   input wire logic [gpk_pkg::PIN_W-1:0] pin_out,
   input wire logic [gpk_pkg::PIN_W-1:0] pin_oe,
   // level the outside circuit pushes onto pins the device leaves undriven
   input wire logic [gpk_pkg::PIN_W-1:0] ext_level,
   // resolved wire level fed back to the device
   output logic [gpk_pkg::PIN_W-1:0] pin_level
);
   timeunit 1ns;
   timeprecision 100ps;
   // a driving device wins; elsewhere the outside source sets the level,
   // so a floating pin never reads back the last driven value
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

//--- sim/gpk_port_tb.sv
// self-checking bench for the port k data block
module gpk_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] DA = gpk_pkg::PIN_DATA_ADDR;
   localparam logic [31:0] DR = gpk_pkg::PIN_DIR_ADDR;
   localparam logic [31:0] FN = gpk_pkg::PIN_FUNC_ADDR;
   localparam logic [31:0] GR = gpk_pkg::BUS_GROUP_ADDR;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic wdt_reset = 1'h0;
   logic hw_standby = 1'h0;
   logic output_disable_n = 1'h1;
   gpk_pkg::gpk_bus_req_s bus_req = '0;
   gpk_pkg::gpk_alt_s alt_in = '0;
   logic [15:0] ext_level = 16'h0000;
   logic [31:0] bus_rdata;
   logic [15:0] pin_in, pin_out, pin_oe;
   int bad_count = 0;
   int checks_done = 0;

   // 40 MHz clock
   always #12.5 clk = ~clk;

   gpk_port dut (.clk(clk), .rst(rst), .wdt_reset(wdt_reset), .hw_standby(hw_standby),
      .bus_req(bus_req), .bus_rdata(bus_rdata), .alt_in(alt_in), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .output_disable_n(output_disable_n));
   gpk_pins_model ext (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
      .pin_level(pin_in));

   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [3:0] be);
      @(posedge clk);
      bus_req.addr <= a;
      bus_req.wdata <= {16'h0000, d};
      bus_req.be <= be;
      bus_req.wr <= 1'h1;
      @(posedge clk);
      bus_req.wr <= 1'h0;
   endtask

   // read strobe, data sampled in the following cycle only
   task automatic rchk(input logic [31:0] a, input logic [15:0] exp, input string what);
      @(posedge clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'h1;
      @(posedge clk);
      bus_req.rd <= 1'h0;
      #1;
      chk(bus_rdata, {16'h0000, exp}, what);
   endtask

   // let the pin filter and output flops settle
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // pulse one of the clear inputs for four cycles
   task automatic pulse(input int which);
      @(posedge clk);
      if (which == 0) rst <= 1'h1;
      else if (which == 1) wdt_reset <= 1'h1;
      else hw_standby <= 1'h1;
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      wdt_reset <= 1'h0;
      hw_standby <= 1'h0;
      @(posedge clk);
   endtask

   // verdict, the single exit of the run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // watchdog, far beyond the roughly 150 cycles the tests need
   initial begin
      #(25 * 5000);
      bad_count++;
      $display("BAD %0t watchdog expired", $time);
      end_sim();
   end

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      rchk(DA, 16'h0000, "data after reset");
      rchk(DR, 16'h0000, "direction after reset");
      rchk(32'hFFFFF790, 16'h0000, "unmapped read");
      chk({16'h0000, pin_oe}, 32'h00000000, "drive after reset");
      $display("done: reset values");
      // general outputs, halfword then byte lanes
      wr(DR, 16'hFFFF, 4'h3);
      wr(DA, 16'h00A5, 4'h3);
      cyc(3);
      chk({16'h0000, pin_out}, 32'h000000A5, "output level");
      chk({16'h0000, pin_oe}, 32'h0000FFFF, "output enable");
      rchk(DA, 16'h00A5, "stored read");
      wr(DA, 16'h3C00, 4'h2);
      rchk(DA, 16'h3CA5, "high byte write");
      wr(DA, 16'h11FF, 4'h1);
      rchk(DA, 16'h3CFF, "low byte write");
      wr(DA, 16'h2222, 4'hC);
      rchk(DA, 16'h3CFF, "upper lanes ignored");
      wr(32'hFFFFF790, 16'h5A5A, 4'h3);
      cyc(20);
      rchk(DA, 16'h3CFF, "held, unmapped write ignored");
      $display("done: general output");
      // general inputs
      wr(DR, 16'h0000, 4'h3);
      ext_level <= 16'h1234;
      cyc(6);
      rchk(DA, 16'h1234, "pin read");
      wr(DA, 16'hBEEF, 4'h3);
      cyc(3);
      chk({16'h0000, pin_oe}, 32'h00000000, "input not driven");
      rchk(DA, 16'h1234, "pin read after write");
      wr(DR, 16'hFFFF, 4'h3);
      rchk(DA, 16'hBEEF, "write was stored");
      $display("done: general input");
      // other function on all pins, high byte direction 0
      @(posedge clk);
      alt_in <= '{out: 16'h0F0F, oe: 16'hFFFF};
      wr(FN, 16'hFFFF, 4'h3);
      wr(DR, 16'h00FF, 4'h3);
      wr(DA, 16'h6666, 4'h3);
      cyc(6);
      chk({16'h0000, pin_out}, 32'h00000F0F, "function keeps pin");
      rchk(DA, 16'h0F66, "mixed read source");
      $display("done: other function");
      // output disable on bus-group pins
      wr(FN, 16'h000F, 4'h3);
      wr(GR, 16'h00FF, 4'h3);
      wr(DR, 16'hFFFF, 4'h3);
      wr(DA, 16'hA5A5, 4'h3);
      cyc(3);
      chk({16'h0000, pin_out}, 32'h0000A5AF, "bus pins driven");
      @(posedge clk);
      output_disable_n <= 1'h0;
      #1;
      chk({16'h0000, pin_oe}, 32'h0000FF0F, "disable without clock");
      cyc(2);
      chk({16'h0000, pin_oe}, 32'h0000FF0F, "disable held");
      @(posedge clk);
      output_disable_n <= 1'h1;
      #1;
      chk({16'h0000, pin_oe}, 32'h0000FFFF, "disable released");
      $display("done: output disable");
      // clears: watchdog keeps data, standby and power-on clear it
      pulse(1);
      rchk(DR, 16'h0000, "direction after watchdog");
      wr(DR, 16'hFFFF, 4'h3);
      rchk(DA, 16'hA5A5, "data kept by watchdog");
      pulse(2);
      wr(DR, 16'hFFFF, 4'h3);
      rchk(DA, 16'h0000, "data after standby");
      wr(DA, 16'h1357, 4'h3);
      pulse(0);
      wr(DR, 16'hFFFF, 4'h3);
      rchk(DA, 16'h0000, "data after second reset");
      $display("done: clears");
      end_sim();
   end
endmodule
